// *** rtl/boot_seq_pkg.sv ***
// Package for the boot power sequencer: codes, fixed-boot defaults, slot timing.
// Assumes a single 200 MHz clock domain.
package boot_seq_pkg;

  localparam int  CLK_MHZ          = 200;
  localparam int  SLOT_SHORT_US    = 500;
  localparam int  SLOT_LONG_US     = 2000;
  localparam int  SLOT_SHORT_CYC   = SLOT_SHORT_US * CLK_MHZ;
  localparam int  SLOT_LONG_CYC    = SLOT_LONG_US * CLK_MHZ;
  localparam int  SLOT_COUNT       = 15;
  localparam int  RES_COUNT        = 5;

  localparam logic [3:0] SLOT_OFF  = 4'h0;
  localparam logic [3:0] SLOT_LAST = 4'hF;
  localparam logic [3:0] SLOT_FIRST = 4'h1;

  // Resource indices in the enable vector.
  localparam int  RES_CORE_A       = 0;
  localparam int  RES_CORE_B       = 1;
  localparam int  RES_IO           = 2;
  localparam int  RES_EXT          = 3;
  localparam int  RES_LIN_REG_FIVE = 4;

  // Core rail level codes, 100 mV and 50 mV steps from 0.6 V to 1.5 V.
  typedef enum logic [3:0] {
    LVL_0V60, LVL_0V70, LVL_0V80, LVL_0V85, LVL_0V90, LVL_1V00, LVL_1V05, LVL_1V10,
    LVL_1V15, LVL_1V20, LVL_1V25, LVL_1V30, LVL_1V35, LVL_1V40, LVL_1V50, LVL_RSVD
  } core_level_t;

  localparam logic [6:0] EXT_CODE_OFF = 7'h00;
  localparam logic [6:0] EXT_CODE_3   = 7'h03;
  localparam logic [6:0] EXT_CODE_11  = 7'h0B;
  localparam logic [6:0] EXT_CODE_19  = 7'h13;
  localparam logic [6:0] EXT_CODE_23  = 7'h17;
  localparam logic [6:0] EXT_CODE_27  = 7'h1B;
  localparam logic [6:0] EXT_CODE_59  = 7'h3B;
  localparam logic [6:0] EXT_CODE_63  = 7'h3F;
  localparam logic [6:0] EXT_CODE_67  = 7'h43;
  localparam logic [7:0] RATIO_NUM    = 8'h30;
  localparam logic [7:0] RATIO_BASE   = 8'h2D;

  localparam logic [4:0] LDO_1V0_CODE = 5'h00;

  typedef struct packed {
    core_level_t core_a_level;
    logic        core_a_gain_x2;
    logic        core_a_pulse_skip_enable;
    logic [3:0]  core_a_slot;
    core_level_t core_b_level;
    logic        core_b_gain_x3;
    logic        core_b_pulse_skip_enable;
    logic [3:0]  core_b_slot;
    logic        io_rail_pulse_skip_enable;
    logic [3:0]  io_slot;
    logic [6:0]  ext_code;
    logic [3:0]  ext_slot;
    logic [4:0]  linear_regulator_five_sel;
    logic [3:0]  linear_regulator_five_slot;
    logic        slot_duration_select;
  } boot_cfg_t;

  localparam boot_cfg_t FIXED_CFG = '{
    core_a_level: LVL_1V20, core_a_gain_x2: 1'b0, core_a_pulse_skip_enable: 1'b1, core_a_slot: 4'h3,
    core_b_level: LVL_1V50, core_b_gain_x3: 1'b0, core_b_pulse_skip_enable: 1'b1, core_b_slot: 4'h6,
    io_rail_pulse_skip_enable: 1'b1, io_slot: 4'h4,
    ext_code: EXT_CODE_OFF, ext_slot: SLOT_OFF,
    linear_regulator_five_sel: LDO_1V0_CODE, linear_regulator_five_slot: SLOT_OFF,
    slot_duration_select: 1'b1
  };

endpackage

// *** rtl/boot_cfg_store.sv ***
// Small store for the nonvolatile boot image; read data come from a register.
// Assumes the whole image is loaded in one write before the power-up request.
`timescale 1ns/1ps
module boot_cfg_store (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      wr_en,
  input  wire boot_seq_pkg::boot_cfg_t   wr_data,
  input  wire logic                      rd_en,
  output      boot_seq_pkg::boot_cfg_t   rd_data
);

  boot_seq_pkg::boot_cfg_t mem_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q <= boot_seq_pkg::FIXED_CFG;
    end else if (wr_en) begin
      mem_q <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= boot_seq_pkg::FIXED_CFG;
    end else if (rd_en) begin
      rd_data <= mem_q;
    end
  end

endmodule

// *** rtl/boot_power_sequencer.sv ***
// Boot power sequencer: picks fixed or stored boot settings and steps 15 slots.
// Assumes synchronous inputs on CLK at 200 MHz and an active-low async reset.
//
// Behaviour
// - Core rail A boots at 1.2 V.
// - Core rail A enables in slot 3.
// - Core A gain x1 or x2, default x1.
// - Pulse skip on for both cores and IO.
// - Core rail B boots at 1.5 V.
// - Core rail B enables in slot 6.
// - Core B gain x1 or x3, default x1.
// - IO rail enables in slot 4.
// - External code from eight values, default off.
// - External ratio equals 48 over 45 plus code.
// - External control has no slot by default.
// - Regulator five 1 V code, no slot.
// - Fifteen ordered slots switch resources on.
// - Slot lasts 0.5 ms or 2 ms.
// - Unassigned resources stay off after sequence.
// - Boot pin low fixed, high stored.
`timescale 1ns/1ps
module boot_power_sequencer #(
  parameter int SLOT_SHORT_CYC = boot_seq_pkg::SLOT_SHORT_CYC,
  parameter int SLOT_LONG_CYC  = boot_seq_pkg::SLOT_LONG_CYC
) (
  input  wire logic                      CLK,
  input  wire logic                      RST_N,
  input  wire logic                      BOOT_MODE_PIN,
  input  wire logic                      POWER_UP_REQ,
  input  wire logic                      STORE_WR_EN,
  input  wire boot_seq_pkg::boot_cfg_t   STORE_WR_DATA,
  output      boot_seq_pkg::boot_cfg_t   ACTIVE_CFG,
  output      logic [4:0]                RAIL_ENABLE,
  output      logic [3:0]                CURRENT_SLOT,
  output      logic                      SEQ_BUSY,
  output      logic                      SEQ_DONE,
  output      logic                      EXT_CODE_VALID,
  output      logic [7:0]                EXT_RATIO_DEN
);

  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_WAIT, S_RUN, S_DONE} seq_state_t;

  seq_state_t              state_q;
  logic                    boot_mode_q;
  logic                    boot_taken_q;
  boot_seq_pkg::boot_cfg_t stored_cfg;
  logic [3:0]              slot_q;
  logic [18:0]             tick_q;
  logic                    slot_end;
  logic [3:0]              res_slot [boot_seq_pkg::RES_COUNT];
  logic [4:0]              slot_hit;

  boot_cfg_store boot_cfg_store_inst (
    .clk     (CLK),
    .rst_n   (RST_N),
    .wr_en   (STORE_WR_EN),
    .wr_data (STORE_WR_DATA),
    .rd_en   (state_q == S_LOAD),
    .rd_data (stored_cfg)
  );

  // The boot pin is captured once, on the first clock after reset release.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      boot_mode_q  <= 1'b0;
      boot_taken_q <= 1'b0;
    end else if (!boot_taken_q) begin
      boot_mode_q  <= BOOT_MODE_PIN;
      boot_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: if (POWER_UP_REQ && boot_taken_q) state_q <= S_LOAD;
        S_LOAD: state_q <= S_WAIT;
        S_WAIT: state_q <= S_RUN;
        S_RUN:  if (slot_end && slot_q == boot_seq_pkg::SLOT_LAST) state_q <= S_DONE;
        S_DONE: state_q <= S_DONE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Settings are latched on the same clock edge that starts slot 1.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACTIVE_CFG <= boot_seq_pkg::FIXED_CFG;
    end else if (state_q == S_WAIT) begin
      ACTIVE_CFG <= boot_mode_q ? stored_cfg : boot_seq_pkg::FIXED_CFG;
    end
  end

  assign slot_end = ACTIVE_CFG.slot_duration_select ?
                    (tick_q == 19'(SLOT_LONG_CYC - 1)) : (tick_q == 19'(SLOT_SHORT_CYC - 1));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_q <= '0;
      slot_q <= boot_seq_pkg::SLOT_OFF;
    end else if (state_q == S_WAIT) begin
      tick_q <= '0;
      slot_q <= boot_seq_pkg::SLOT_FIRST;
    end else if (state_q == S_RUN) begin
      if (slot_end) begin
        tick_q <= '0;
        if (slot_q != boot_seq_pkg::SLOT_LAST) slot_q <= slot_q + 4'h1;
      end else begin
        tick_q <= tick_q + 19'h0_0001;
      end
    end
  end

  assign res_slot[boot_seq_pkg::RES_CORE_A] = ACTIVE_CFG.core_a_slot;
  assign res_slot[boot_seq_pkg::RES_CORE_B] = ACTIVE_CFG.core_b_slot;
  assign res_slot[boot_seq_pkg::RES_IO]     = ACTIVE_CFG.io_slot;
  assign res_slot[boot_seq_pkg::RES_EXT]    = ACTIVE_CFG.ext_slot;
  assign res_slot[boot_seq_pkg::RES_LIN_REG_FIVE] = ACTIVE_CFG.linear_regulator_five_slot;

  // A resource turns on one clock after the start of its slot; slot code zero means never.
  // One clocked process owns the whole enable vector, so no bit has two writers.
  for (genvar r = 0; r < boot_seq_pkg::RES_COUNT; r++) begin : g_res
    assign slot_hit[r] = (state_q == S_RUN) && (res_slot[r] != boot_seq_pkg::SLOT_OFF) &&
                         (res_slot[r] == slot_q);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RAIL_ENABLE <= '0;
    end else begin
      RAIL_ENABLE <= RAIL_ENABLE | slot_hit;
    end
  end

  always_comb begin
    unique case (ACTIVE_CFG.ext_code)
      boot_seq_pkg::EXT_CODE_3, boot_seq_pkg::EXT_CODE_11, boot_seq_pkg::EXT_CODE_19,
      boot_seq_pkg::EXT_CODE_23, boot_seq_pkg::EXT_CODE_27, boot_seq_pkg::EXT_CODE_59,
      boot_seq_pkg::EXT_CODE_63, boot_seq_pkg::EXT_CODE_67: EXT_CODE_VALID = 1'b1;
      default: EXT_CODE_VALID = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      EXT_RATIO_DEN <= boot_seq_pkg::RATIO_BASE;
    end else begin
      EXT_RATIO_DEN <= boot_seq_pkg::RATIO_BASE + {1'b0, ACTIVE_CFG.ext_code};
    end
  end

  assign CURRENT_SLOT = (state_q == S_RUN) ? slot_q : boot_seq_pkg::SLOT_OFF;
  assign SEQ_BUSY     = (state_q == S_LOAD) || (state_q == S_WAIT) || (state_q == S_RUN);
  assign SEQ_DONE     = (state_q == S_DONE);

  property p_slot_enable;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == S_RUN && ACTIVE_CFG.core_a_slot != 4'h0 && slot_q == ACTIVE_CFG.core_a_slot)
      |=> RAIL_ENABLE[0];
  endproperty
  a_slot_enable: assert property (p_slot_enable) else $error("Core A not enabled in its slot");

  property p_no_early;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == S_RUN && slot_q < ACTIVE_CFG.core_b_slot && !RAIL_ENABLE[1]) |=> !RAIL_ENABLE[1];
  endproperty
  a_no_early: assert property (p_no_early) else $error("Core B enabled before its slot");

  property p_unassigned_off;
    @(posedge CLK) disable iff (!RST_N) (state_q == S_DONE && ACTIVE_CFG.ext_slot == 4'h0) |-> !RAIL_ENABLE[3];
  endproperty
  a_unassigned_off: assert property (p_unassigned_off) else $error("Unassigned resource on");

  property p_fixed_defaults;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == S_RUN && !boot_mode_q) |-> (ACTIVE_CFG.core_a_level == boot_seq_pkg::LVL_1V20 &&
        ACTIVE_CFG.core_b_level == boot_seq_pkg::LVL_1V50 && !ACTIVE_CFG.core_a_gain_x2 &&
        !ACTIVE_CFG.core_b_gain_x3 && ACTIVE_CFG.io_slot == 4'h4);
  endproperty
  a_fixed_defaults: assert property (p_fixed_defaults) else $error("Fixed boot settings wrong");

  property p_pulse_skip;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == S_RUN && !boot_mode_q) |-> (ACTIVE_CFG.core_a_pulse_skip_enable &&
        ACTIVE_CFG.core_b_pulse_skip_enable && ACTIVE_CFG.io_rail_pulse_skip_enable);
  endproperty
  a_pulse_skip: assert property (p_pulse_skip) else $error("Pulse skip not enabled");

  property p_stored_mode;
    @(posedge CLK) disable iff (!RST_N) (state_q == S_WAIT && boot_mode_q) |=> (ACTIVE_CFG == $past(stored_cfg));
  endproperty
  a_stored_mode: assert property (p_stored_mode) else $error("Stored settings not taken");

  property p_slot_len;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == S_RUN && slot_end && slot_q != boot_seq_pkg::SLOT_LAST) |=> (slot_q == $past(slot_q) + 4'h1);
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("Slot did not advance");

  property p_ratio;
    @(posedge CLK) disable iff (!RST_N)
      1'b1 |=> (EXT_RATIO_DEN == boot_seq_pkg::RATIO_BASE + {1'b0, $past(ACTIVE_CFG.ext_code)});
  endproperty
  a_ratio: assert property (p_ratio) else $error("Ratio denominator wrong");

  sequence s_start_req;
    state_q == S_IDLE && POWER_UP_REQ && boot_taken_q;
  endsequence

  sequence s_load_to_run;
    (state_q == S_LOAD) ##1 (state_q == S_WAIT) ##1 (state_q == S_RUN && slot_q == boot_seq_pkg::SLOT_FIRST);
  endsequence

  property p_start;
    @(posedge CLK) disable iff (!RST_N) s_start_req |=> s_load_to_run;
  endproperty
  a_start: assert property (p_start) else $error("Sequence did not start at slot one");

  property p_done_hold;
    @(posedge CLK) disable iff (!RST_N) SEQ_DONE |=> (SEQ_DONE && !SEQ_BUSY);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("Sequence left the done state");

  property p_pin_once;
    @(posedge CLK) disable iff (!RST_N) boot_taken_q |=> $stable(boot_mode_q);
  endproperty
  a_pin_once: assert property (p_pin_once) else $error("Boot mode changed after capture");

  property p_same_slot;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == S_RUN && ACTIVE_CFG.core_a_slot != boot_seq_pkg::SLOT_OFF &&
       ACTIVE_CFG.core_a_slot == ACTIVE_CFG.core_b_slot && slot_q == ACTIVE_CFG.core_a_slot)
      |=> (RAIL_ENABLE[boot_seq_pkg::RES_CORE_A] && RAIL_ENABLE[boot_seq_pkg::RES_CORE_B]);
  endproperty
  a_same_slot: assert property (p_same_slot) else $error("Same-slot rails not enabled together");

endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the boot power sequencer: fixed boot, then stored boot for each converter code.
// Assumes the sequencer's own assertions are compiled with it; slot lengths are shortened by parameters.
`timescale 1ns/1ps
module testbench;
  localparam int SHORT_CYC = 4;
  localparam int LONG_CYC  = 16;
  logic                    CLK;
  logic                    RST_N;
  logic                    BOOT_MODE_PIN;
  logic                    POWER_UP_REQ;
  logic                    STORE_WR_EN;
  boot_seq_pkg::boot_cfg_t STORE_WR_DATA;
  boot_seq_pkg::boot_cfg_t ACTIVE_CFG;
  boot_seq_pkg::boot_cfg_t fixed_exp;
  boot_seq_pkg::boot_cfg_t img;
  logic [4:0]              RAIL_ENABLE;
  logic [3:0]              CURRENT_SLOT;
  logic                    SEQ_BUSY;
  logic                    SEQ_DONE;
  logic                    EXT_CODE_VALID;
  logic [7:0]              EXT_RATIO_DEN;
  logic [6:0]              codes [9];
  int                      n_fail;
  int                      compares;

  boot_power_sequencer #(.SLOT_SHORT_CYC(SHORT_CYC), .SLOT_LONG_CYC(LONG_CYC)) boot_power_sequencer_inst (
    .CLK(CLK), .RST_N(RST_N), .BOOT_MODE_PIN(BOOT_MODE_PIN), .POWER_UP_REQ(POWER_UP_REQ),
    .STORE_WR_EN(STORE_WR_EN), .STORE_WR_DATA(STORE_WR_DATA), .ACTIVE_CFG(ACTIVE_CFG),
    .RAIL_ENABLE(RAIL_ENABLE), .CURRENT_SLOT(CURRENT_SLOT), .SEQ_BUSY(SEQ_BUSY), .SEQ_DONE(SEQ_DONE),
    .EXT_CODE_VALID(EXT_CODE_VALID), .EXT_RATIO_DEN(EXT_RATIO_DEN));

  always #2.5 CLK = ~CLK;

  task automatic step;
    @(posedge CLK);
    #1;
  endtask

  task automatic chk_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cfg(input string what, input boot_seq_pkg::boot_cfg_t exp, input boot_seq_pkg::boot_cfg_t got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Holds reset for five cycles with the boot pin set, then flips the pin after its capture edge.
  task automatic do_reset(input logic mode);
    RST_N = 1'b0;
    BOOT_MODE_PIN = mode;
    repeat (5) step();
    chk_cfg("reset cfg", fixed_exp, ACTIVE_CFG);
    chk_vec("reset den", 8'h2D, EXT_RATIO_DEN);
    chk_vec("reset enables", 8'h00, {3'h0, RAIL_ENABLE});
    chk_vec("reset status", 8'h00, {2'h0, SEQ_BUSY, SEQ_DONE, CURRENT_SLOT});
    RST_N = 1'b1;
    step();
    BOOT_MODE_PIN = ~mode;
    step();
  endtask

  // Requests a sequence and checks every cycle of every slot against the expected image.
  task automatic run_seq(input boot_seq_pkg::boot_cfg_t cfg, input int len);
    logic [3:0] slots [5];
    logic [4:0] en;
    int         w;
    slots = '{cfg.core_a_slot, cfg.core_b_slot, cfg.io_slot, cfg.ext_slot, cfg.linear_regulator_five_slot};
    POWER_UP_REQ = 1'b1;
    step();
    POWER_UP_REQ = 1'b0;
    chk_vec("busy in load", 8'h01, {7'h0, SEQ_BUSY});
    w = 0;
    while (CURRENT_SLOT !== 4'h1 && w < 10) begin
      step();
      w++;
    end
    if (w == 10) begin
      n_fail++;
      $display("Error slot start expected 1 seen %h", CURRENT_SLOT);
      end_of_test();
    end
    chk_cfg("active cfg", cfg, ACTIVE_CFG);
    for (int s = 1; s <= 15; s++) begin
      for (int k = 0; k < len; k++) begin
        for (int i = 0; i < 5; i++) en[i] = (slots[i] != 0) && (slots[i] < s || (slots[i] == s && k > 0));
        chk_vec("slot", s[7:0], {4'h0, CURRENT_SLOT});
        chk_vec("enables", {3'h0, en}, {3'h0, RAIL_ENABLE});
        chk_vec("busy", 8'h01, {7'h0, SEQ_BUSY});
        step();
      end
    end
    w = 0;
    while (SEQ_DONE !== 1'b1 && w < 2) begin
      step();
      w++;
    end
    for (int i = 0; i < 5; i++) en[i] = (slots[i] != 0);
    chk_vec("done", 8'h01, {7'h0, SEQ_DONE});
    chk_vec("final enables", {3'h0, en}, {3'h0, RAIL_ENABLE});
    chk_vec("busy after done", 8'h00, {7'h0, SEQ_BUSY});
    POWER_UP_REQ = 1'b1;
    STORE_WR_EN = 1'b1;
    STORE_WR_DATA = fixed_exp;
    step();
    POWER_UP_REQ = 1'b0;
    STORE_WR_EN = 1'b0;
    repeat (3) step();
    chk_cfg("cfg after refused request", cfg, ACTIVE_CFG);
    chk_vec("slot after refused request", 8'h00, {4'h0, CURRENT_SLOT});
    chk_vec("done after refused request", 8'h01, {7'h0, SEQ_DONE});
  endtask

  task automatic test_fixed;
    do_reset(1'b0);
    run_seq(fixed_exp, LONG_CYC);
    chk_vec("fixed den", 8'h2D, EXT_RATIO_DEN);
    chk_vec("fixed ext valid", 8'h00, {7'h0, EXT_CODE_VALID});
    $display("test_fixed finished");
  endtask

  task automatic test_stored(input logic [6:0] code);
    do_reset(1'b1);
    img = '{core_a_level: boot_seq_pkg::LVL_0V60, core_a_gain_x2: 1'b1, core_a_pulse_skip_enable: 1'b0,
            core_a_slot: 4'h2, core_b_level: boot_seq_pkg::LVL_1V40, core_b_gain_x3: 1'b1,
            core_b_pulse_skip_enable: 1'b0, core_b_slot: 4'h2, io_rail_pulse_skip_enable: 1'b0,
            io_slot: 4'h5, ext_code: code, ext_slot: 4'h1, linear_regulator_five_sel: 5'h1F,
            linear_regulator_five_slot: 4'hF, slot_duration_select: 1'b0};
    STORE_WR_DATA = img;
    STORE_WR_EN = 1'b1;
    step();
    STORE_WR_EN = 1'b0;
    run_seq(img, SHORT_CYC);
    chk_vec("stored den", 8'h2D + {1'b0, code}, EXT_RATIO_DEN);
    chk_vec("stored ext valid", {7'h0, (code inside {7'h03, 7'h0B, 7'h13, 7'h17, 7'h1B, 7'h3B, 7'h3F, 7'h43})},
            {7'h0, EXT_CODE_VALID});
    $display("test_stored finished for code %h", code);
  endtask

  initial begin
    CLK = 1'b0;
    RST_N = 1'b0;
    BOOT_MODE_PIN = 1'b0;
    POWER_UP_REQ = 1'b0;
    STORE_WR_EN = 1'b0;
    n_fail = 0;
    compares = 0;
    fixed_exp = '{core_a_level: boot_seq_pkg::LVL_1V20, core_a_gain_x2: 1'b0, core_a_pulse_skip_enable: 1'b1,
                  core_a_slot: 4'h3, core_b_level: boot_seq_pkg::LVL_1V50, core_b_gain_x3: 1'b0,
                  core_b_pulse_skip_enable: 1'b1, core_b_slot: 4'h6, io_rail_pulse_skip_enable: 1'b1,
                  io_slot: 4'h4, ext_code: 7'h00, ext_slot: 4'h0, linear_regulator_five_sel: 5'h00,
                  linear_regulator_five_slot: 4'h0, slot_duration_select: 1'b1};
    STORE_WR_DATA = fixed_exp;
    codes = '{7'h03, 7'h0B, 7'h13, 7'h17, 7'h1B, 7'h3B, 7'h3F, 7'h43, 7'h05};
    test_fixed();
    for (int i = 0; i < 9; i++) test_stored(codes[i]);
    end_of_test();
  end
endmodule
